/* rx_port_pkg.sv */
// Purpose: shared constants and helpers for the receive output port
// Assumes: 50 MHz system clock, byte-wide register port
// Notes:   field positions and counts live here only
package rx_port_pkg;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] ADDR_POWER_CTRL   = 8'h02;
    localparam logic [7:0] ADDR_ROUTE_CTRL   = 8'h03;
    localparam logic [7:0] ADDR_VIDEO_CLAMP  = 8'h07;
    localparam logic [7:0] ADDR_CLOCK_SELECT = 8'h08;
    localparam logic [7:0] ADDR_PORT_STATUS  = 8'h09;

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int         REF_PD_BIT        = 0;
    localparam int         NARROW_PD_BIT     = 1;
    localparam int         ROUTE_SECOND_BIT  = 6;
    localparam int         VIDEO_EN_BIT      = 7;
    localparam int         CLK_DIRECT_BIT    = 0;
    localparam int         CLAMP_MSB         = 6;
    localparam logic [7:0] POWER_CTRL_RESET  = 8'h00;
    localparam logic [7:0] ROUTE_CTRL_RESET  = 8'h00;
    localparam logic [7:0] VIDEO_CLAMP_RESET = 8'h00;
    localparam logic [7:0] CLOCK_SEL_RESET   = 8'h00;

    // ****************************************
    // timing
    // ****************************************
    localparam longint CLK_HZ      = 50_000_000;
    localparam longint MAX_SPS     = 29_000_000;
    localparam int     MIN_GAP     = int'((CLK_HZ + MAX_SPS - 1) / MAX_SPS);
    localparam int     FIFO_DEPTH  = 32;

    // straight binary: two's complement with the sign flipped, clipped on overrange
    function automatic logic [11:0] wide_code(input logic [11:0] s, input logic over, input logic under);
        if (over)
            return 12'hFFF;
        else if (under)
            return 12'h000;
        else
            return {~s[11], s[10:0]};
    endfunction : wide_code

    function automatic logic [9:0] narrow_code(input logic [9:0] s, input logic over, input logic under);
        if (over)
            return 10'h3FF;
        else if (under)
            return 10'h000;
        else
            return {~s[9], s[8:0]};
    endfunction : narrow_code

endpackage : rx_port_pkg

/* rx_sample_fifo.sv */
// Purpose: flip-flop FIFO holding converter result sets
// Assumes: single clock, push and pop may coincide
// Notes:   out_data is read straight from storage
`timescale 1ns/1ps
module rx_sample_fifo #(
    parameter int WIDTH = 34,
    parameter int DEPTH = 32
) (
    input  wire logic                       clk,       // system clock
    input  wire logic                       rst,       // async reset, high
    input  wire logic                       in_valid,  // push request
    output logic                            in_ready,  // room for a word
    input  wire logic [WIDTH-1:0]           in_data,   // pushed word
    output logic                            out_valid, // word available
    input  wire logic                       out_ready, // pop request
    output logic [WIDTH-1:0]                out_data,  // oldest word
    output logic [$clog2(DEPTH+1)-1:0]      level      // words held
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial begin
        if (DEPTH < 2 || WIDTH < 1)
            $error("fifo needs depth of two or more");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic             push;
    logic             pop;

    assign in_ready  = (level != DEPTH[$clog2(DEPTH+1)-1:0]);
    assign out_valid = (level != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr];

    always_ff @(posedge clk) begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level  <= '0;
        end else begin
            if (push)
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            if (push && !pop)
                level <= level + 1'b1;
            else if (pop && !push)
                level <= level - 1'b1;
        end
    end

    fifo_no_overrun_a: assert property (@(posedge clk) disable iff (rst)
        level <= DEPTH) else $error("fifo level above depth");

endmodule : rx_sample_fifo

/* rx_adc_output_port.sv */
// Purpose: receive output port: muxes converter results onto wide and narrow ports
// Assumes: results arrive on clk; word_clk is the output word clock from the link side
// Notes:   one result set is shown per two word_clk cycles, repeated if none is new
//
// What this block does
// - both wide converter results share one 12-bit output bus
// - word clock runs at twice sample rate, one word per cycle
// - accepted sample sets never exceed 29 MSPS
// - converter clock is taken from oscillator input or from multiplier
// - output words are straight binary, saturating at all ones and all zeros
// - both output ports update on each rising word clock edge
// - frame marker flags the first word of each narrow port symbol unless the narrow converter is powered down
// - a full set of results is shown every two word clock cycles
// - frame marker is high on every second narrow word unless powered down
// - register 0x02 powers down internal converter references
// - enabled video input clamps black level to the clamp field of 0x07
// - after reset video input is disabled and disconnected
// - writing bit 7 of 0x07 enables and connects the video input
// - bit 6 of 0x03 routes video to first or second wide converter
// - register 0x08 selects direct oscillator or multiplier converter clock
`timescale 1ns/1ps
module rx_adc_output_port
    import rx_port_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic        clk,                   // system clock, 50 MHz
    input  wire logic        rst,                   // async reset, high
    input  wire logic        word_clk,              // output word clock
    input  wire logic        reg_write,             // register write strobe
    input  wire logic [7:0]  reg_addr,              // register offset
    input  wire logic [7:0]  reg_wdata,             // write data
    output logic      [7:0]  reg_rdata,             // read data of reg_addr
    input  wire logic        sample_valid,          // converter set ready
    output logic             sample_ready,          // set will be taken
    input  wire logic [11:0] first_wide_sample,     // first wide converter, two's complement
    input  wire logic        first_wide_over,       // first wide above full scale
    input  wire logic        first_wide_under,      // first wide below full scale
    input  wire logic [11:0] second_wide_sample,    // second wide converter
    input  wire logic        second_wide_over,      // second wide above full scale
    input  wire logic        second_wide_under,     // second wide below full scale
    input  wire logic [9:0]  narrow_sample,         // narrow converter
    input  wire logic        narrow_over,           // narrow above full scale
    input  wire logic        narrow_under,          // narrow below full scale
    output logic      [11:0] wide_if_output,        // wide port, word_clk domain
    output logic      [9:0]  narrow_if_output,      // narrow port, word_clk domain
    output logic             rx_frame_marker,       // first word of a symbol
    output logic             ref_power_down,        // internal references off
    output logic             narrow_power_down,     // narrow converter off
    output logic             adc_clk_direct,        // converters clocked from oscillator_input
    output logic             video_to_first,        // video on first_wide_converter
    output logic             video_to_second,       // video on second_wide_converter
    output logic             clamp_enable,          // video clamp active
    output logic      [6:0]  clamp_level            // black level target
);
    localparam int SW = 34;
    localparam int LW = $clog2(DEPTH + 1);

    initial begin
        if (DEPTH < 2 || DEPTH > 255)
            $error("depth must be 2 to 255");
    end

    // ****************************************
    // register file
    // ****************************************
    logic [7:0] power_ctrl;
    logic [7:0] route_ctrl;
    logic [7:0] video_clamp_control;
    logic [7:0] clock_select;
    logic [LW-1:0] fifo_level;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            power_ctrl          <= POWER_CTRL_RESET;
            route_ctrl          <= ROUTE_CTRL_RESET;
            video_clamp_control <= VIDEO_CLAMP_RESET;
            clock_select        <= CLOCK_SEL_RESET;
        end else if (reg_write) begin
            // writes to unmapped offsets are dropped without any indication
            case (reg_addr)
                ADDR_POWER_CTRL:   power_ctrl          <= reg_wdata;
                ADDR_ROUTE_CTRL:   route_ctrl          <= reg_wdata;
                ADDR_VIDEO_CLAMP:  video_clamp_control <= reg_wdata;
                ADDR_CLOCK_SELECT: clock_select        <= reg_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else begin
            case (reg_addr)
                ADDR_POWER_CTRL:   reg_rdata <= power_ctrl;
                ADDR_ROUTE_CTRL:   reg_rdata <= route_ctrl;
                ADDR_VIDEO_CLAMP:  reg_rdata <= video_clamp_control;
                ADDR_CLOCK_SELECT: reg_rdata <= clock_select;
                ADDR_PORT_STATUS:  reg_rdata <= 8'(fifo_level);
                default:           reg_rdata <= 8'h00;
            endcase
        end
    end

    // ****************************************
    // analog controls
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ref_power_down    <= 1'b0;
            narrow_power_down <= 1'b0;
            adc_clk_direct    <= 1'b0;
            video_to_first    <= 1'b0;
            video_to_second   <= 1'b0;
            clamp_enable      <= 1'b0;
            clamp_level       <= 7'h00;
        end else begin
            ref_power_down    <= power_ctrl[REF_PD_BIT];
            narrow_power_down <= power_ctrl[NARROW_PD_BIT];
            adc_clk_direct    <= clock_select[CLK_DIRECT_BIT];
            video_to_first    <= video_clamp_control[VIDEO_EN_BIT] && !route_ctrl[ROUTE_SECOND_BIT];
            video_to_second   <= video_clamp_control[VIDEO_EN_BIT] && route_ctrl[ROUTE_SECOND_BIT];
            clamp_enable      <= video_clamp_control[VIDEO_EN_BIT];
            clamp_level       <= video_clamp_control[CLAMP_MSB:0];
        end
    end

    video_route_a: assert property (@(posedge clk) disable iff (rst)
        !(video_to_first && video_to_second) && (video_to_first || video_to_second) == clamp_enable)
        else $error("video routed to both or without enable");
    video_enable_a: assert property (@(posedge clk) disable iff (rst)
        reg_write && reg_addr == ADDR_VIDEO_CLAMP ##1 1'b1 |=> clamp_enable == $past(reg_wdata[VIDEO_EN_BIT], 2)
            && clamp_level == $past(reg_wdata[6:0], 2))
        else $error("clamp enable or level not taken from write");

    // ****************************************
    // sample intake, rate limited
    // ****************************************
    logic [$clog2(MIN_GAP+1)-1:0] gap_cnt;
    logic                         accept;
    logic                         fifo_in_ready;
    logic                         fifo_out_valid;
    logic                         pop;
    logic [SW-1:0]                fifo_out;
    logic [LW-1:0]                next_level;

    // gap counter keeps takes two clocks apart, 25 MSPS at 50 MHz
    assign accept     = sample_valid && sample_ready;
    assign next_level = fifo_level + LW'(accept) - LW'(pop);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gap_cnt      <= '0;
            sample_ready <= 1'b0;
        end else begin
            if (accept)
                gap_cnt <= ($bits(gap_cnt))'(MIN_GAP - 1);
            else if (gap_cnt != '0)
                gap_cnt <= gap_cnt - 1'b1;
            // ready is registered, so it looks one cycle ahead at both limits
            sample_ready <= (next_level != LW'(DEPTH)) && (accept ? (MIN_GAP <= 1) : (gap_cnt <= 1));
        end
    end

    rate_limit_a: assert property (@(posedge clk) disable iff (rst)
        accept |=> !accept) else $error("two sets taken back to back");
    fifo_room_a: assert property (@(posedge clk) disable iff (rst)
        accept |-> fifo_in_ready) else $error("set taken with fifo full");

    // converter words coded once, so the buffer and the checks see the same set
    logic [SW-1:0] set_word;
    assign set_word = {wide_code(first_wide_sample, first_wide_over, first_wide_under),
                       wide_code(second_wide_sample, second_wide_over, second_wide_under),
                       narrow_code(narrow_sample, narrow_over, narrow_under)};

    rx_sample_fifo #(
        .WIDTH (SW),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (accept),
        .in_ready  (fifo_in_ready),
        .in_data   (set_word),
        .out_valid (fifo_out_valid),
        .out_ready (pop),
        .out_data  (fifo_out),
        .level     (fifo_level)
    );

    sat_code_a: assert property (@(posedge clk) disable iff (rst)
        accept && first_wide_over |-> set_word[33:22] == 12'hFFF)
        else $error("wide word not all ones on overrange");
    sat_low_a: assert property (@(posedge clk) disable iff (rst)
        accept && first_wide_under && !first_wide_over |-> set_word[33:22] == 12'h000)
        else $error("wide word not all zeros on underrange");
    narrow_code_a: assert property (@(posedge clk) disable iff (rst)
        accept && !narrow_over && !narrow_under |-> set_word[9:0] == (narrow_sample ^ 10'h200))
        else $error("narrow word not straight binary");

    // ****************************************
    // word handover to word_clk, toggle handshake
    // ****************************************
    logic [SW-1:0] xfer_data;
    logic          xfer_req;
    logic          ack_s1;
    logic          ack_s2;
    logic          busy;
    logic          link_ack;

    // the word crosses whole while req and ack differ; only the toggle bits are synchronised

    assign busy = (xfer_req != ack_s2);
    assign pop  = fifo_out_valid && !busy;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            xfer_data <= '0;
            xfer_req  <= 1'b0;
        end else if (pop) begin
            xfer_data <= fifo_out;
            xfer_req  <= ~xfer_req;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
        end else begin
            ack_s1 <= link_ack;
            ack_s2 <= ack_s1;
        end
    end

    xfer_stable_a: assert property (@(posedge clk) disable iff (rst)
        busy |=> $stable(xfer_data)) else $error("handover word changed while pending");

    // ****************************************
    // word clock domain
    // ****************************************
    logic          link_rst_s1;
    logic          link_rst;
    logic          req_s1;
    logic          req_s2;
    logic          pd_s1;
    logic          pd_s2;
    logic [SW-1:0] shown;

    typedef enum logic [1:0] {
        FIRST_WORD  = 2'b01,
        SECOND_WORD = 2'b10
    } word_phase_t;
    word_phase_t phase;

    always_ff @(posedge word_clk or posedge rst) begin
        if (rst) begin
            link_rst_s1 <= 1'b1;
            link_rst    <= 1'b1;
        end else begin
            link_rst_s1 <= 1'b0;
            link_rst    <= link_rst_s1;
        end
    end

    always_ff @(posedge word_clk or posedge link_rst) begin
        if (link_rst) begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            pd_s1  <= 1'b0;
            pd_s2  <= 1'b0;
        end else begin
            req_s1 <= xfer_req;
            req_s2 <= req_s1;
            pd_s1  <= power_ctrl[NARROW_PD_BIT];
            pd_s2  <= pd_s1;
        end
    end

    // a new set is taken only at a symbol boundary so both words match
    always_ff @(posedge word_clk or posedge link_rst) begin
        if (link_rst) begin
            phase    <= FIRST_WORD;
            shown    <= {12'h800, 12'h800, 10'h200};
            link_ack <= 1'b0;
        end else begin
            case (phase)
                FIRST_WORD:  phase <= SECOND_WORD;
                SECOND_WORD: begin
                    phase <= FIRST_WORD;
                    if (req_s2 != link_ack) begin
                        shown    <= xfer_data;
                        link_ack <= req_s2;
                    end
                end
                default:     phase <= FIRST_WORD;
            endcase
        end
    end

    always_ff @(posedge word_clk or posedge link_rst) begin
        if (link_rst) begin
            wide_if_output   <= 12'h000;
            narrow_if_output <= 10'h000;
            rx_frame_marker  <= 1'b0;
        end else begin
            case (phase)
                FIRST_WORD: begin
                    wide_if_output   <= shown[33:22];
                    narrow_if_output <= shown[9:0];
                    rx_frame_marker  <= !pd_s2;
                end
                SECOND_WORD: begin
                    wide_if_output   <= shown[21:10];
                    narrow_if_output <= shown[9:0];
                    rx_frame_marker  <= 1'b0;
                end
                default: begin
                    wide_if_output   <= 12'h000;
                    narrow_if_output <= 10'h000;
                    rx_frame_marker  <= 1'b0;
                end
            endcase
        end
    end

    // outputs lag the phase by one edge, so the expected words are the shown set of the edge before
    marker_alt_a: assert property (@(posedge word_clk) disable iff (link_rst)
        rx_frame_marker |=> !rx_frame_marker) else $error("marker high two words running");
    marker_pd_a: assert property (@(posedge word_clk) disable iff (link_rst)
        pd_s2 && $past(pd_s2) |=> !rx_frame_marker) else $error("marker moved while powered down");
    marker_cadence_a: assert property (@(posedge word_clk) disable iff (link_rst)
        !pd_s2 && phase == FIRST_WORD |=> rx_frame_marker ##1 !rx_frame_marker
            ##1 (rx_frame_marker || $past(pd_s2)))
        else $error("marker not on every second word");
    wide_mux_a: assert property (@(posedge word_clk) disable iff (link_rst)
        phase == SECOND_WORD && $stable(shown) |=> wide_if_output == $past(shown[21:10])
            ##1 wide_if_output == $past(shown[33:22]))
        else $error("wide port order wrong");
    narrow_repeat_a: assert property (@(posedge word_clk) disable iff (link_rst)
        phase == SECOND_WORD |=> narrow_if_output == $past(shown[9:0]))
        else $error("narrow port not repeated in second word");

endmodule : rx_adc_output_port

/* rx_host_model.sv */
// Purpose: host receive logic that captures the output port words
// Assumes: words are taken on the rising word clock edge
// Notes:   a set is published once the word after a marked word arrives
`timescale 1ns/1ps
module rx_host_model (
    input  wire logic        word_clk,   // output word clock
    input  wire logic [11:0] wide,       // wide port
    input  wire logic [9:0]  narrow,     // narrow port
    input  wire logic        marker,     // frame marker
    output logic      [11:0] got_first,  // first wide word of last set
    output logic      [11:0] got_second, // second wide word of last set
    output logic      [9:0]  got_narrow, // narrow word of last set
    output int               marks       // markers seen so far
);
    logic        in_frame = 1'b0;
    logic [11:0] held     = 12'h000;
    initial begin
        got_first  = 12'h000;
        got_second = 12'h000;
        got_narrow = 10'h000;
        marks      = 0;
    end
    // align on the marker, then pair the next word with it
    always @(posedge word_clk) begin
        if (marker === 1'b1) begin
            marks    <= marks + 1;
            held     <= wide;
            in_frame <= 1'b1;
        end else if (in_frame) begin
            got_first  <= held;
            got_second <= wide;
            got_narrow <= narrow;
            in_frame   <= 1'b0;
        end
    end
endmodule : rx_host_model

/* test_rx_adc_output_port.sv */
// Purpose: self-checking bench for the receive output port
// Assumes: word clock made here at 48 ns, free of the system clock
// Notes:   random sets come from a fixed-seed xorshift
`timescale 1ns/1ps
module test_rx_adc_output_port;
    logic        clk = 0, rst = 1, word_clk = 0, reg_write = 0, sample_valid = 0, sample_ready;
    logic        fo = 0, fu = 0, so = 0, su = 0, no = 0, nu = 0, mk;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [11:0] fs = 12'h000, ss = 12'h000, wo, g1, g2;
    logic [9:0]  ns = 10'h000, no_w, gn;
    logic [6:0]  clamp_level;
    logic [5:0]  ctl;
    logic [31:0] seed = 32'h65756176;
    int          fails = 0, checks_done = 0, marks, m0, n;
    logic [7:0]  ra [7] = '{8'h07, 8'h03, 8'h02, 8'h08, 8'h05, 8'h07, 8'h02};
    logic [7:0]  rv [7] = '{8'h85, 8'h40, 8'h03, 8'h01, 8'hFF, 8'h00, 8'h00};
    logic [5:0]  rc [7] = '{6'h05, 6'h03, 6'h33, 6'h3B, 6'h3B, 6'h38, 6'h08};

    always #10 clk = ~clk;
    // free word clock, odd phase against clk
    initial begin
        #7;
        forever #24 word_clk = ~word_clk;
    end

    rx_adc_output_port uut (.clk, .rst, .word_clk, .reg_write, .reg_addr, .reg_wdata, .reg_rdata,
        .sample_valid, .sample_ready, .first_wide_sample(fs), .first_wide_over(fo), .first_wide_under(fu),
        .second_wide_sample(ss), .second_wide_over(so), .second_wide_under(su), .narrow_sample(ns),
        .narrow_over(no), .narrow_under(nu), .wide_if_output(wo), .narrow_if_output(no_w),
        .rx_frame_marker(mk), .ref_power_down(ctl[5]), .narrow_power_down(ctl[4]),
        .adc_clk_direct(ctl[3]), .video_to_first(ctl[2]), .video_to_second(ctl[1]),
        .clamp_enable(ctl[0]), .clamp_level);
    rx_host_model host (.word_clk, .wide(wo), .narrow(no_w), .marker(mk), .got_first(g1),
        .got_second(g2), .got_narrow(gn), .marks);

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic logic [11:0] ew(input logic [11:0] s, input logic o, input logic u);
        return o ? 12'hFFF : (u ? 12'h000 : (s ^ 12'h800));
    endfunction : ew
    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic stop_test();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_write = 1;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge clk);
        reg_write = 0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        reg_addr = a;
        @(negedge clk);
        chk("reg read", {4'h0, exp}, {4'h0, reg_rdata});
    endtask : rd
    // waits for room; a stuck ready ends the run
    task automatic push();
        n = 0;
        while (sample_ready !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > 300) begin
                fails++;
                stop_test();
            end
        end
        sample_valid = 1;
        @(negedge clk);
        sample_valid = 0;
    endtask : push

    initial begin
        repeat (16) @(negedge clk);
        rst = 0;
        @(negedge clk);
        chk("ctl reset", 12'h000, {6'h00, ctl});
        rd(8'h07, 8'h00);
        $display("test reset done");
        // ****************************************
        // result sets: corners first, then random
        // ****************************************
        for (int i = 0; i < 14; i++) begin
            {fs, ss, ns} = 34'({rnd(), rnd()});
            {fo, fu, so, su, no, nu} = (i < 4) ? {6{i[0]}} & {i[1], ~i[1] | i[0], i[1], 1'b1, i[1], 1'b1} : 6'h00;
            if (i == 0) {fs, ss, ns} = 34'h0;
            if (i == 4) {fs, ss, ns} = {12'h7FF, 12'h800, 10'h1FF};
            if (i > 4 && rnd() % 6 == 0) {fo, su} = 2'b11;
            push();
            n = 0;
            while ({g1, g2, gn} !== {ew(fs, fo, fu), ew(ss, so, su), 10'(ew({ns, 2'b00}, no, nu) >> 2)}
                   && n < 400) begin
                @(negedge clk);
                n++;
            end
            if (n >= 400) begin
                fails++;
                stop_test();
            end
            chk("first word", ew(fs, fo, fu), g1);
            chk("second word", ew(ss, so, su), g2);
            chk("narrow word", ew({ns, 2'b00}, no, nu) >> 2, {2'b00, gn});
        end
        $display("test sets done");
        // ****************************************
        // fill the buffer until it refuses, then drain
        // ****************************************
        m0 = 0;
        // ready and valid both stand through the coming edge, so each count is one take
        for (int c = 0; c < 300; c++) begin
            sample_valid = 1;
            m0 += (sample_ready === 1'b1);
            @(negedge clk);
        end
        // end on a take, so the buffer is known full for the read that follows
        n = 0;
        while (sample_ready !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        if (n >= 300) begin
            fails++;
            stop_test();
        end
        @(negedge clk);
        sample_valid = 0;
        chk("rate held", 12'h001, {11'h0, m0 <= 150});
        rd(8'h09, 8'h20);
        for (n = 0; n < 1000 && reg_rdata !== 8'h00; n++) begin
            @(negedge clk);
        end
        if (n >= 1000) begin
            fails++;
            stop_test();
        end
        chk("drained", 12'h000, {4'h0, reg_rdata});
        $display("test buffer done");
        // ****************************************
        // control registers
        // ****************************************
        for (int i = 0; i < 7; i++) begin
            wr(ra[i], rv[i]);
            @(negedge clk);
            chk("controls", {6'h00, rc[i]}, {6'h00, ctl});
            if (i == 0) chk("clamp level", 12'h005, {5'h00, clamp_level});
            rd(ra[i], (ra[i] == 8'h05) ? 8'h00 : rv[i]);
            m0 = marks;
            repeat (40) @(negedge clk);
            if (i == 4) chk("marker off", 12'h000, 12'(marks - m0));
            if (i == 6) chk("marker on", 12'h001, {11'h0, marks - m0 > 4});
        end
        $display("test registers done");
        stop_test();
    end
endmodule : test_rx_adc_output_port
